// ===== design/mad_datapath.sv
// arithmetic logic datapath of the one-clock-per-cycle core
`timescale 1ns/1ps
module mad_datapath (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] ext_operand,
  input wire logic sfr_wr,
  input wire logic [1:0] sfr_sel,
  input wire logic [7:0] sfr_wdata,
  output logic op_ready,
  output logic op_done,
  output logic op_illegal,
  output logic [1:0] op_bytes,
  output logic [7:0] acc_out,
  output logic [7:0] b_out,
  output logic [7:0] flags_out,
  output logic [15:0] ptr_out,
  output logic [7:0] result_out,
  output logic result_valid
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [7:0] acc_ff;
  logic [7:0] b_ff;
  logic [7:0] flags_ff;
  logic [15:0] ptr_ff;
  logic [2:0] cnt_ff;
  logic ready_ff;
  logic done_ff;
  logic ill_ff;
  logic [1:0] bytes_ff;
  logic [7:0] res_ff;
  logic res_vld_ff;
  logic [7:0] pend_res_ff;
  logic [7:0] pend_flags_ff;
  mad_pkg::mad_dst_t pend_dst_ff;

  logic [7:0] nxt_acc;
  logic [7:0] nxt_b;
  logic [7:0] nxt_flags;
  logic [15:0] nxt_ptr;
  logic [2:0] nxt_cnt;

  logic accept;
  logic commit_now;
  logic commit_late;
  logic c_go;
  logic [7:0] c_res;
  logic [7:0] c_flags;
  mad_pkg::mad_dst_t c_dst;
  logic sfr_take;

  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [7:0] step_src;
  logic [8:0] wide;
  logic [4:0] nib;
  logic cin;

  mad_dec_if dec_bus ();
  mad_md_if md_bus ();

  // --------------------------------------------------------------
  // decode and multiply/divide
  // --------------------------------------------------------------
  assign dec_bus.opcode = opcode;

  mad_decode u_decode (
    .d(dec_bus)
  );

  assign md_bus.start = accept && (dec_bus.dst == mad_pkg::DST_AB);
  assign md_bus.sel_div = (dec_bus.op == mad_pkg::OP_DIV);
  assign md_bus.a = acc_ff;
  assign md_bus.b = b_ff;

  mad_muldiv u_muldiv (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .m(md_bus)
  );

  // --------------------------------------------------------------
  // issue and completion
  // --------------------------------------------------------------
  assign accept = op_valid && ready_ff;
  assign commit_now = accept && (dec_bus.cycles == mad_pkg::CYC_ONE);
  assign commit_late = (cnt_ff == mad_pkg::CYC_ONE);
  assign c_go = commit_now || commit_late;
  assign c_res = commit_now ? alu_res : pend_res_ff;
  assign c_flags = commit_now ? alu_flags : pend_flags_ff;
  assign c_dst = commit_now ? dec_bus.dst : pend_dst_ff;
  // side writes only while idle so pending operands stay intact
  assign sfr_take = sfr_wr && ready_ff && !accept;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (accept) begin
      nxt_cnt = dec_bus.cycles - mad_pkg::CYC_ONE;
    end else if (cnt_ff != mad_pkg::CYC_ZERO) begin
      nxt_cnt = cnt_ff - mad_pkg::CYC_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= mad_pkg::CYC_ZERO;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      ill_ff <= 1'b0;
      bytes_ff <= mad_pkg::LEN_ONE;
    end else begin
      cnt_ff <= nxt_cnt;
      // ready rises with the last cycle so the next fetch overlaps
      ready_ff <= (nxt_cnt == mad_pkg::CYC_ZERO);
      done_ff <= c_go;
      ill_ff <= accept && !dec_bus.legal;
      if (accept) begin
        bytes_ff <= dec_bus.bytes;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_res_ff <= mad_pkg::BYTE_RST;
      pend_flags_ff <= mad_pkg::BYTE_RST;
      pend_dst_ff <= mad_pkg::DST_ACC;
    end else if (accept) begin
      pend_res_ff <= alu_res;
      pend_flags_ff <= alu_flags;
      pend_dst_ff <= dec_bus.dst;
    end
  end

  // --------------------------------------------------------------
  // arithmetic and logic
  // --------------------------------------------------------------
  assign step_src = (dec_bus.dst == mad_pkg::DST_ACC) ? acc_ff : ext_operand;
  assign cin = (dec_bus.op == mad_pkg::OP_ADD_CY) && flags_ff[mad_pkg::FLG_CY];

  always_comb begin
    alu_res = acc_ff;
    alu_flags = flags_ff;
    wide = {1'b0, acc_ff};
    nib = {1'b0, acc_ff[3:0]};
    case (dec_bus.op)
      mad_pkg::OP_ADD, mad_pkg::OP_ADD_CY: begin
        wide = {1'b0, acc_ff} + {1'b0, ext_operand} + {8'h00, cin};
        nib = {1'b0, acc_ff[3:0]} + {1'b0, ext_operand[3:0]} + {4'h0, cin};
        alu_res = wide[7:0];
        alu_flags[mad_pkg::FLG_CY] = wide[8];
        alu_flags[mad_pkg::FLG_AC] = nib[4];
        alu_flags[mad_pkg::FLG_OV] = (acc_ff[7] == ext_operand[7]) && (wide[7] != acc_ff[7]);
      end
      mad_pkg::OP_SUB_BW: begin
        wide = {1'b0, acc_ff} - {1'b0, ext_operand} - {8'h00, flags_ff[mad_pkg::FLG_CY]};
        nib = {1'b0, acc_ff[3:0]} - {1'b0, ext_operand[3:0]}
              - {4'h0, flags_ff[mad_pkg::FLG_CY]};
        alu_res = wide[7:0];
        alu_flags[mad_pkg::FLG_CY] = wide[8];
        alu_flags[mad_pkg::FLG_AC] = nib[4];
        alu_flags[mad_pkg::FLG_OV] = (acc_ff[7] != ext_operand[7]) && (wide[7] != acc_ff[7]);
      end
      mad_pkg::OP_INC: alu_res = step_src + mad_pkg::BYTE_ONE;
      mad_pkg::OP_DEC: alu_res = step_src - mad_pkg::BYTE_ONE;
      mad_pkg::OP_AND: alu_res = acc_ff & ext_operand;
      mad_pkg::OP_OR: alu_res = acc_ff | ext_operand;
      mad_pkg::OP_XOR: alu_res = acc_ff ^ ext_operand;
      mad_pkg::OP_CPL: alu_res = ~acc_ff;
      mad_pkg::OP_CLR: alu_res = mad_pkg::BYTE_RST;
      mad_pkg::OP_RL: alu_res = {acc_ff[6:0], acc_ff[7]};
      mad_pkg::OP_RR: alu_res = {acc_ff[0], acc_ff[7:1]};
      mad_pkg::OP_RLC: begin
        alu_res = {acc_ff[6:0], flags_ff[mad_pkg::FLG_CY]};
        alu_flags[mad_pkg::FLG_CY] = acc_ff[7];
      end
      mad_pkg::OP_RRC: begin
        alu_res = {flags_ff[mad_pkg::FLG_CY], acc_ff[7:1]};
        alu_flags[mad_pkg::FLG_CY] = acc_ff[0];
      end
      mad_pkg::OP_SWAP: alu_res = {acc_ff[3:0], acc_ff[7:4]};
      mad_pkg::OP_BCD: begin
        if (acc_ff[3:0] > mad_pkg::NIB_MAX || flags_ff[mad_pkg::FLG_AC]) begin
          wide = wide + mad_pkg::BCD_LO;
        end
        if (wide[7:4] > mad_pkg::NIB_MAX || wide[8] || flags_ff[mad_pkg::FLG_CY]) begin
          wide = wide + mad_pkg::BCD_HI;
        end
        alu_res = wide[7:0];
        // carry is only ever set here, never cleared
        alu_flags[mad_pkg::FLG_CY] = flags_ff[mad_pkg::FLG_CY] | wide[8];
      end
      default: alu_res = acc_ff;
    endcase
  end

  // --------------------------------------------------------------
  // write-back
  // --------------------------------------------------------------
  always_comb begin
    nxt_acc = acc_ff;
    nxt_b = b_ff;
    nxt_flags = flags_ff;
    nxt_ptr = ptr_ff;
    if (c_go) begin
      case (c_dst)
        mad_pkg::DST_ACC: begin
          nxt_acc = c_res;
          nxt_flags = c_flags;
        end
        mad_pkg::DST_EXT: nxt_flags = c_flags;
        mad_pkg::DST_AB: begin
          nxt_acc = md_bus.lo;
          nxt_b = md_bus.hi;
          nxt_flags[mad_pkg::FLG_CY] = 1'b0;
          nxt_flags[mad_pkg::FLG_OV] = md_bus.ov;
        end
        mad_pkg::DST_DP: nxt_ptr = ptr_ff + mad_pkg::DP_ONE;
        default: nxt_acc = acc_ff;
      endcase
    end else if (sfr_take) begin
      case (sfr_sel)
        mad_pkg::SEL_ACC: nxt_acc = sfr_wdata;
        mad_pkg::SEL_B: nxt_b = sfr_wdata;
        mad_pkg::SEL_FLG: nxt_flags = sfr_wdata;
        default: nxt_acc = acc_ff;
      endcase
    end
    nxt_flags[mad_pkg::FLG_P] = ^nxt_acc;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff <= mad_pkg::BYTE_RST;
      b_ff <= mad_pkg::BYTE_RST;
    end else begin
      acc_ff <= nxt_acc;
      b_ff <= nxt_b;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= mad_pkg::BYTE_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ff <= mad_pkg::DP_RST;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_ff <= mad_pkg::BYTE_RST;
      res_vld_ff <= 1'b0;
    end else begin
      res_vld_ff <= c_go && (c_dst == mad_pkg::DST_EXT);
      if (c_go && (c_dst == mad_pkg::DST_EXT)) begin
        res_ff <= c_res;
      end
    end
  end

  assign op_ready = ready_ff;
  assign op_done = done_ff;
  assign op_illegal = ill_ff;
  assign op_bytes = bytes_ff;
  assign acc_out = acc_ff;
  assign b_out = b_ff;
  assign flags_out = flags_ff;
  assign ptr_out = ptr_ff;
  assign result_out = res_ff;
  assign result_valid = res_vld_ff;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_take_md;
    accept && (dec_bus.op == mad_pkg::OP_MUL || dec_bus.op == mad_pkg::OP_DIV);
  endsequence

  sequence s_md_wait;
    !ready_ff [*4] ##1 (ready_ff && done_ff);
  endsequence

  property p_one_cycle;
    commit_now |=> ready_ff && done_ff;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("one-cycle op late");

  property p_overlap;
    done_ff |-> ready_ff;
  endproperty
  a_overlap: assert property (p_overlap) else $error("no overlap at completion");

  property p_add;
    accept && dec_bus.op == mad_pkg::OP_ADD && commit_now
      |=> acc_ff == 8'($past(acc_ff) + $past(ext_operand));
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");

  property p_borrow;
    accept && dec_bus.op == mad_pkg::OP_SUB_BW && commit_now
      |=> flags_ff[mad_pkg::FLG_CY] == ({1'b0, $past(acc_ff)}
          < {1'b0, $past(ext_operand)} + {8'h00, $past(flags_ff[mad_pkg::FLG_CY])});
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow flag wrong");

  property p_parity;
    flags_ff[mad_pkg::FLG_P] == ^acc_ff;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag stale");

  property p_cpl;
    accept && dec_bus.op == mad_pkg::OP_CPL |=> acc_ff == ~$past(acc_ff);
  endproperty
  a_cpl: assert property (p_cpl) else $error("complement wrong");

  property p_swap;
    accept && dec_bus.op == mad_pkg::OP_SWAP
      |=> acc_ff == {$past(acc_ff[3:0]), $past(acc_ff[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_md_time;
    s_take_md |=> s_md_wait;
  endproperty
  a_md_time: assert property (p_md_time) else $error("mul/div not five cycles");

  property p_mul_val;
    accept && dec_bus.op == mad_pkg::OP_MUL
      |-> ##5 {b_ff, acc_ff} == 16'($past(acc_ff, 5) * $past(b_ff, 5));
  endproperty
  a_mul_val: assert property (p_mul_val) else $error("product wrong");

  property p_dec_reg;
    accept && dec_bus.op == mad_pkg::OP_DEC && dec_bus.cycles == mad_pkg::CYC_TWO
      |=> !ready_ff ##1 (result_valid && result_out == 8'($past(ext_operand, 2) - 8'h01));
  endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("register step-down wrong");

  property p_data_pointer_pair;
    accept && dec_bus.op == mad_pkg::OP_INCDP |=> ptr_ff == 16'($past(ptr_ff) + 16'h0001);
  endproperty
  a_data_pointer_pair: assert property (p_data_pointer_pair) else $error("pointer increment wrong");

endmodule

// ===== design/mad_pkg.sv
// shared types and constants for the arithmetic datapath
package mad_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADD_CY, OP_SUB_BW, OP_INC, OP_DEC, OP_AND, OP_OR, OP_XOR,
    OP_CLR, OP_CPL, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SWAP, OP_INCDP,
    OP_MUL, OP_DIV, OP_BCD
  } mad_op_t;

  typedef enum logic [1:0] {DST_ACC, DST_EXT, DST_AB, DST_DP} mad_dst_t;

  // opcode families by high nibble
  localparam logic [3:0] HI_INC = 4'h0;
  localparam logic [3:0] HI_DEC = 4'h1;
  localparam logic [3:0] HI_ADD = 4'h2;
  localparam logic [3:0] HI_ADD_CY = 4'h3;
  localparam logic [3:0] HI_OR = 4'h4;
  localparam logic [3:0] HI_AND = 4'h5;
  localparam logic [3:0] HI_XOR = 4'h6;
  localparam logic [3:0] HI_SUB_BW = 4'h9;

  // addressing forms by low nibble
  localparam logic [3:0] LO_ACC = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [3:0] LO_IND0 = 4'h6;
  localparam logic [3:0] LO_IND1 = 4'h7;
  localparam int REG_BIT = 3;

  // single opcodes
  localparam logic [7:0] OPC_CLR = 8'he4;
  localparam logic [7:0] OPC_CPL = 8'hf4;
  localparam logic [7:0] OPC_RL = 8'h23;
  localparam logic [7:0] OPC_RLC = 8'h33;
  localparam logic [7:0] OPC_RR = 8'h03;
  localparam logic [7:0] OPC_RRC = 8'h13;
  localparam logic [7:0] OPC_SWAP = 8'hc4;
  localparam logic [7:0] OPC_INCDP = 8'ha3;
  localparam logic [7:0] OPC_MUL = 8'ha4;
  localparam logic [7:0] OPC_DIV = 8'h84;
  localparam logic [7:0] OPC_BCD = 8'hd4;

  // cycle counts and lengths
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_MULDIV = 3'h5;
  localparam logic [2:0] CYC_ZERO = 3'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  // flag positions in the program flags register
  localparam int FLG_CY = 7;
  localparam int FLG_AC = 6;
  localparam int FLG_OV = 2;
  localparam int FLG_P = 0;

  localparam logic [1:0] SEL_ACC = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [1:0] SEL_FLG = 2'h2;

  localparam logic [3:0] NIB_MAX = 4'h9;
  localparam logic [8:0] BCD_LO = 9'h006;
  localparam logic [8:0] BCD_HI = 9'h060;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] DP_ONE = 16'h0001;
  localparam logic [15:0] DP_RST = 16'h0000;

endpackage

// ===== design/mad_if.sv
// decode and multiply/divide carriers inside the datapath
`timescale 1ns/1ps
interface mad_dec_if;
  logic [7:0] opcode;
  mad_pkg::mad_op_t op;
  mad_pkg::mad_dst_t dst;
  logic [2:0] cycles;
  logic [1:0] bytes;
  logic legal;
  modport ctl (output opcode, input op, dst, cycles, bytes, legal);
  modport dec (input opcode, output op, dst, cycles, bytes, legal);
endinterface

interface mad_md_if;
  logic start;
  logic sel_div;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] lo;
  logic [7:0] hi;
  logic ov;
  modport ctl (output start, sel_div, a, b, input lo, hi, ov);
  modport unit (input start, sel_div, a, b, output lo, hi, ov);
endinterface

// ===== design/mad_decode.sv
// opcode decoder: operation, destination, length and cycle count
`timescale 1ns/1ps
module mad_decode (
  mad_dec_if.dec d
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic step;

  assign hi = d.opcode[7:4];
  assign lo = d.opcode[3:0];
  assign step = (hi == mad_pkg::HI_INC) || (hi == mad_pkg::HI_DEC);

  always_comb begin
    d.op = mad_pkg::OP_NOP;
    d.dst = mad_pkg::DST_ACC;
    d.cycles = mad_pkg::CYC_ONE;
    d.bytes = mad_pkg::LEN_ONE;
    d.legal = 1'b1;
    case (d.opcode)
      mad_pkg::OPC_CLR: d.op = mad_pkg::OP_CLR;
      mad_pkg::OPC_CPL: d.op = mad_pkg::OP_CPL;
      mad_pkg::OPC_RL: d.op = mad_pkg::OP_RL;
      mad_pkg::OPC_RLC: d.op = mad_pkg::OP_RLC;
      mad_pkg::OPC_RR: d.op = mad_pkg::OP_RR;
      mad_pkg::OPC_RRC: d.op = mad_pkg::OP_RRC;
      mad_pkg::OPC_SWAP: d.op = mad_pkg::OP_SWAP;
      mad_pkg::OPC_BCD: d.op = mad_pkg::OP_BCD;
      mad_pkg::OPC_INCDP: begin
        d.op = mad_pkg::OP_INCDP;
        d.dst = mad_pkg::DST_DP;
      end
      mad_pkg::OPC_MUL, mad_pkg::OPC_DIV: begin
        d.op = (d.opcode == mad_pkg::OPC_MUL) ? mad_pkg::OP_MUL : mad_pkg::OP_DIV;
        d.dst = mad_pkg::DST_AB;
        d.cycles = mad_pkg::CYC_MULDIV;
      end
      default: begin
        case (hi)
          mad_pkg::HI_ADD: d.op = mad_pkg::OP_ADD;
          mad_pkg::HI_ADD_CY: d.op = mad_pkg::OP_ADD_CY;
          mad_pkg::HI_SUB_BW: d.op = mad_pkg::OP_SUB_BW;
          mad_pkg::HI_INC: d.op = mad_pkg::OP_INC;
          mad_pkg::HI_DEC: d.op = mad_pkg::OP_DEC;
          mad_pkg::HI_AND: d.op = mad_pkg::OP_AND;
          mad_pkg::HI_OR: d.op = mad_pkg::OP_OR;
          mad_pkg::HI_XOR: d.op = mad_pkg::OP_XOR;
          default: d.legal = 1'b0;
        endcase
        // step forms write back outside unless they target the accumulator
        if (lo[mad_pkg::REG_BIT]) begin
          d.cycles = step ? mad_pkg::CYC_TWO : mad_pkg::CYC_ONE;
          d.dst = step ? mad_pkg::DST_EXT : mad_pkg::DST_ACC;
        end else if (lo == mad_pkg::LO_DIR) begin
          d.bytes = mad_pkg::LEN_TWO;
          d.cycles = step ? mad_pkg::CYC_THREE : mad_pkg::CYC_TWO;
          d.dst = step ? mad_pkg::DST_EXT : mad_pkg::DST_ACC;
        end else if (lo == mad_pkg::LO_IND0 || lo == mad_pkg::LO_IND1) begin
          d.cycles = step ? mad_pkg::CYC_THREE : mad_pkg::CYC_TWO;
          d.dst = step ? mad_pkg::DST_EXT : mad_pkg::DST_ACC;
        end else if (lo == mad_pkg::LO_ACC) begin
          d.bytes = step ? mad_pkg::LEN_ONE : mad_pkg::LEN_TWO;
          d.cycles = step ? mad_pkg::CYC_ONE : mad_pkg::CYC_TWO;
        end else begin
          d.legal = 1'b0;
        end
        if (!d.legal) begin
          d.op = mad_pkg::OP_NOP;
          d.dst = mad_pkg::DST_ACC;
          d.cycles = mad_pkg::CYC_ONE;
          d.bytes = mad_pkg::LEN_ONE;
        end
      end
    endcase
  end
endmodule

// ===== design/mad_muldiv.sv
// 8x8 product and 8/8 quotient, latched when started
`timescale 1ns/1ps
module mad_muldiv (
  input wire logic ref_clk,
  input wire logic reset_n,
  mad_md_if.unit m
);
  logic [15:0] prod;

  assign prod = m.a * m.b;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      m.lo <= mad_pkg::BYTE_RST;
      m.hi <= mad_pkg::BYTE_RST;
      m.ov <= 1'b0;
    end else if (m.start) begin
      if (!m.sel_div) begin
        m.lo <= prod[7:0];
        m.hi <= prod[15:8];
        m.ov <= (prod[15:8] != mad_pkg::BYTE_RST);
      end else if (m.b == mad_pkg::BYTE_RST) begin
        // divide by zero leaves both operands unchanged
        m.lo <= m.a;
        m.hi <= m.b;
        m.ov <= 1'b1;
      end else begin
        m.lo <= m.a / m.b;
        m.hi <= m.a % m.b;
        m.ov <= 1'b0;
      end
    end
  end
endmodule

// ===== bench/mad_ctl_model.sv
// control unit model offering operations to the datapath
`timescale 1ns/1ps
module mad_ctl_model (
  input wire logic ref_clk,
  input wire logic op_ready,
  output logic op_valid,
  output logic [7:0] opcode,
  output logic [7:0] ext_operand
);
  initial begin
    op_valid = 1'b0;
    opcode = 8'h00;
    ext_operand = 8'h00;
  end
  // offer at a falling edge, hold to the accepting edge
  task automatic issue(input logic [7:0] o, input logic [7:0] x, input logic more);
    @(negedge ref_clk);
    while (op_ready !== 1'b1) begin
      op_valid = 1'b0;
      opcode = ~opcode;
      ext_operand = ~ext_operand;
      @(negedge ref_clk);
    end
    op_valid = 1'b1;
    opcode = o;
    ext_operand = x;
    @(posedge ref_clk);
    if (!more) begin
      @(negedge ref_clk);
      op_valid = 1'b0;
      opcode = ~o;
      ext_operand = ~x;
    end
  endtask
endmodule

// ===== bench/mad_datapath_test.sv
// self-checking bench for the arithmetic datapath
`timescale 1ns/1ps
module mad_datapath_test;
  typedef struct {
    logic [7:0] a, b, p, r;
    logic [15:0] d;
    logic [1:0] by;
    logic rv, il;
    int n;
  } mad_exp_t;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic [1:0] sfr_sel = 2'h0;
  logic [7:0] sfr_wdata = 8'h00;
  logic op_valid, op_ready, op_done, op_illegal, result_valid;
  logic [7:0] opcode, ext_operand, acc_out, b_out, flags_out, result_out;
  logic [1:0] op_bytes;
  logic [15:0] ptr_out;
  logic [7:0] a = 8'h00, b = 8'h00, ps = 8'h00, rs = 8'h00, rnd = 8'h32;
  logic [15:0] dp = 16'h0000;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  mad_exp_t exp_q[$];
  int acc_q[$];
  logic [7:0] ops[$] = '{8'h28, 8'h2f, 8'h25, 8'h26, 8'h24, 8'hd4, 8'h38, 8'h3f, 8'h35,
    8'h37, 8'h34, 8'h98, 8'h9f, 8'h95, 8'h96, 8'h94, 8'h04, 8'h08, 8'h0f, 8'h05, 8'h07,
    8'h14, 8'h18, 8'h1f, 8'h15, 8'h16, 8'ha3, 8'h58, 8'h55, 8'h56, 8'h54, 8'h48, 8'h45,
    8'h47, 8'h44, 8'h68, 8'h66, 8'h64, 8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4,
    8'h52, 8'ha5, 8'ha4, 8'h84};

  always #5 ref_clk = ~ref_clk;

  mad_ctl_model ctl (.ref_clk(ref_clk), .op_ready(op_ready), .op_valid(op_valid),
    .opcode(opcode), .ext_operand(ext_operand));
  mad_datapath DUT (.ref_clk(ref_clk), .reset_n(reset_n), .op_valid(op_valid),
    .opcode(opcode), .ext_operand(ext_operand), .sfr_wr(sfr_wr), .sfr_sel(sfr_sel),
    .sfr_wdata(sfr_wdata), .op_ready(op_ready), .op_done(op_done), .op_illegal(op_illegal),
    .op_bytes(op_bytes), .acc_out(acc_out), .b_out(b_out), .flags_out(flags_out),
    .ptr_out(ptr_out), .result_out(result_out), .result_valid(result_valid));

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // expected state after one operation
  function automatic mad_exp_t ref_op(input logic [7:0] o, input logic [7:0] x);
    mad_exp_t e;
    logic [8:0] t;
    logic [3:0] h, l;
    logic c;
    h = o[7:4];
    l = o[3:0];
    c = ps[7];
    e.rv = 1'b0;
    e.il = 1'b0;
    e.n = 1;
    e.by = 2'h1;
    case (o)
      8'he4: a = 8'h00;
      8'hf4: a = ~a;
      8'h23: a = {a[6:0], a[7]};
      8'h33: {ps[7], a} = {a, c};
      8'h03: a = {a[0], a[7:1]};
      8'h13: {a, ps[7]} = {c, a};
      8'hc4: a = {a[3:0], a[7:4]};
      8'ha3: dp = dp + 16'h0001;
      8'ha4: begin
        {b, a} = a * b;
        ps[7] = 1'b0;
        ps[2] = b != 8'h00;
        e.n = 5;
      end
      8'h84: begin
        ps[7] = 1'b0;
        ps[2] = b == 8'h00;
        if (b != 8'h00) {b, a} = {a % b, a / b};
        e.n = 5;
      end
      8'hd4: begin
        t = {1'b0, a} + ((a[3:0] > 4'h9 || ps[6]) ? 9'h006 : 9'h000);
        c = c | t[8];
        if (c || t[7:4] > 4'h9) t = {1'b0, t[7:0]} + 9'h060;
        ps[7] = c | t[8];
        a = t[7:0];
      end
      default: begin
        e.by = (l == 4'h5 || (l == 4'h4 && h > 4'h1)) ? 2'h2 : 2'h1;
        e.n = (h < 4'h2) ? (l == 4'h4 ? 1 : (l[3] ? 2 : 3)) : (l[3] ? 1 : 2);
        if (l < 4'h4 || (h > 4'h6 && h != 4'h9)) begin
          e.il = 1'b1;
          e.by = 2'h0;
          e.n = 1;
        end else if (h < 4'h2) begin
          t[7:0] = (l == 4'h4 ? a : x) + (h[0] ? 8'hff : 8'h01);
          if (l == 4'h4) a = t[7:0];
          else begin
            rs = t[7:0];
            e.rv = 1'b1;
          end
        end else if (h == 4'h4) a = a | x;
        else if (h == 4'h5) a = a & x;
        else if (h == 4'h6) a = a ^ x;
        else begin
          if (h == 4'h2) c = 1'b0;
          if (h == 4'h9) begin
            t = {1'b0, a} - x - c;
            ps[6] = {1'b0, a[3:0]} < {1'b0, x[3:0]} + c;
            ps[2] = (a[7] != x[7]) && (t[7] != a[7]);
          end else begin
            t = a + x + c;
            ps[6] = {1'b0, a[3:0]} + x[3:0] + c > 5'h0f;
            ps[2] = (a[7] == x[7]) && (t[7] != a[7]);
          end
          ps[7] = t[8];
          a = t[7:0];
        end
      end
    endcase
    e.a = a;
    e.b = b;
    e.p = ps;
    e.r = rs;
    e.d = dp;
    return e;
  endfunction

  task automatic go(input logic [7:0] o, input logic [7:0] x, input logic more);
    exp_q.push_back(ref_op(o, x));
    ctl.issue(o, x, more);
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    while (op_ready !== 1'b1) @(negedge ref_clk);
    sfr_wr = 1'b1;
    sfr_sel = s;
    sfr_wdata = d;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d;
    if (s == 2'h0) a = d;
    else if (s == 2'h1) b = d;
    else if (s == 2'h2) ps = d;
    chk(acc_out, a);
    chk(b_out, b);
    chk(flags_out, {ps[7:1], ^a});
  endtask

  always @(posedge ref_clk) if (op_valid === 1'b1 && op_ready === 1'b1) acc_q.push_back(cyc);

  always @(negedge ref_clk) begin
    mad_exp_t e;
    int t;
    cyc++;
    if (op_done === 1'b1 && exp_q.size() != 0) begin
      e = exp_q.pop_front();
      t = acc_q.pop_front();
      chk(acc_out, e.a);
      chk(b_out, e.b);
      chk(flags_out, {e.p[7:1], ^e.a});
      chk(ptr_out, e.d);
      chk(op_illegal, e.il);
      chk(result_valid, e.rv);
      chk(cyc - t, e.n);
      if (e.rv) chk(result_out, e.r);
      if (e.by != 2'h0) chk(op_bytes, e.by);
    end else chk(op_done, 1'b0);
    if (cyc > 2000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    chk(op_ready, 1'b0);
    chk(op_bytes, 2'h1);
    chk(flags_out, 8'h00);
    reset_n = 1'b1;
    wr(2'h2, 8'hba);
    wr(2'h0, 8'h99);
    wr(2'h1, 8'h07);
    wr(2'h3, 8'h55);
    repeat (2) begin
      foreach (ops[i]) begin
        rnd = lfsr(rnd);
        go(ops[i], rnd, i != ops.size() - 1);
      end
      wr(2'h2, rnd);
    end
    wr(2'h1, 8'h00);
    go(8'h84, 8'h00, 1'b0);
    wr(2'h0, 8'hff);
    wr(2'h1, 8'hff);
    go(8'ha4, 8'h00, 1'b1);
    go(8'h28, 8'h01, 1'b0);
    while (exp_q.size() != 0) @(negedge ref_clk);
    final_report();
  end
endmodule
